// *** src/mfs_filter_stats.v ***
// two-port bridge frame filter with per-port statistics
// assumes all inputs synchronous to clk; event inputs are one-cycle pulses
`default_nettype none
`include "mfs_regs.vh"

module mfs_filter_stats #(
	parameter REFRESH_CYCLES = `MFS_REFRESH_SEC * `MFS_CLK_HZ
) (
	input  wire        clk,
	input  wire        srst,
	input  wire        ce,
	// filter enables
	input  wire        flt_en_eth,
	input  wire        flt_en_rad,
	// table write port
	input  wire        tbl_wr,
	input  wire        tbl_add,
	input  wire        tbl_port,
	input  wire [4:0]  tbl_idx,
	input  wire [47:0] tbl_addr,
	input  wire [47:0] tbl_mask,
	input  wire        tbl_sel,
	input  wire        tbl_act,
	output wire        tbl_full,
	output reg         tbl_add_done,
	output reg         tbl_add_rej,
	output reg  [4:0]  tbl_add_idx,
	// frames to be judged
	input  wire        frm_valid,
	output wire        frm_ready,
	input  wire        frm_port,
	input  wire [47:0] frm_src,
	input  wire [47:0] frm_dst,
	// verdicts
	output wire        dec_valid,
	input  wire        dec_ready,
	output reg         dec_port,
	output reg         dec_fwd,
	output reg  [47:0] dec_src,
	output reg  [47:0] dec_dst,
	// wired port events
	input  wire        eth_tx_done,
	input  wire        eth_rx_done,
	input  wire [15:0] eth_rx_len,
	input  wire        eth_err,
	input  wire        eth_crc_err,
	input  wire        eth_col_err,
	input  wire        clr_eth,
	// radio port events
	input  wire        rad_tx_done,
	input  wire        rad_ack,
	input  wire        rad_nack,
	input  wire        rad_rx_done,
	input  wire        clr_rad,
	output reg         rad_resend,
	output reg         rad_wait_ack,
	// readable counter copies
	output wire [31:0] eth_tx_cnt,
	output wire [31:0] eth_rx_cnt,
	output wire [31:0] eth_err_cnt,
	output wire [31:0] eth_crc_cnt,
	output wire [31:0] eth_col_cnt,
	output wire [31:0] eth_over_cnt,
	output wire [31:0] eth_runt_cnt,
	output wire [31:0] rad_tx_cnt,
	output wire [31:0] rad_retx_cnt,
	output wire [31:0] rad_rx_cnt,
	output reg  [31:0] rad_tx_rate,
	output reg  [31:0] rad_rx_rate,
	output reg         stats_tick
);

	// cut to the timer width on purpose; the default count fits in 30 bits
	localparam integer REF_LAST_I = REFRESH_CYCLES - 1;
	localparam [29:0]  REF_LAST   = REF_LAST_I[29:0];

	////////////////////////////////////////////////////////////////////////////
	// entry storage: index {port, slot}

	reg  [47:0] ent_addr_q [0:2*`MFS_TBL_DEPTH-1];
	reg  [47:0] ent_mask_q [0:2*`MFS_TBL_DEPTH-1];
	reg         ent_sel_q  [0:2*`MFS_TBL_DEPTH-1];
	reg         ent_act_q  [0:2*`MFS_TBL_DEPTH-1];

	// zero address with zero mask is a deleted slot
	function ent_empty;
		input [47:0] a;
		input [47:0] m;
		begin
			ent_empty = (a == `MFS_ENT_RST) && (m == `MFS_ENT_RST);
		end
	endfunction

	function ent_hit;
		input [47:0] a;
		input [47:0] m;
		input [47:0] f;
		begin
			ent_hit = ~ent_empty(a, m) && (((a ^ f) & m) == `MFS_ENT_RST);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// lowest empty slot of the addressed port

	reg         free_any;
	reg  [4:0]  free_idx;
	integer     fi;

	always @* begin
		free_any = 1'b0;
		free_idx = 5'h00;
		// downward scan so the lowest empty slot wins
		for (fi = `MFS_TBL_DEPTH - 1; fi >= 0; fi = fi - 1) begin
			if (ent_empty(ent_addr_q[{tbl_port, fi[4:0]}], ent_mask_q[{tbl_port, fi[4:0]}])) begin
				free_any = 1'b1;
				free_idx = fi[4:0];
			end
		end
	end

	assign tbl_full = ~free_any;

	wire        add_ok;
	wire        wr_any;
	wire [5:0]  wr_slot;

	assign add_ok  = tbl_add & free_any;
	assign wr_any  = tbl_wr | add_ok;
	// an explicit write takes priority over an add in the same cycle
	assign wr_slot = tbl_wr ? {tbl_port, tbl_idx} : {tbl_port, free_idx};

	integer ri;

	always @(posedge clk) begin
		if (srst) begin
			for (ri = 0; ri < 2 * `MFS_TBL_DEPTH; ri = ri + 1) begin
				ent_addr_q[ri] <= `MFS_ENT_RST;
				ent_mask_q[ri] <= `MFS_ENT_RST;
				ent_sel_q[ri]  <= `MFS_SEL_SRC;
				ent_act_q[ri]  <= `MFS_ACT_ACCEPT;
			end
			tbl_add_done <= 1'b0;
			tbl_add_rej  <= 1'b0;
			tbl_add_idx  <= 5'h00;
		end else if (ce) begin
			if (wr_any) begin
				ent_addr_q[wr_slot] <= tbl_addr;
				ent_mask_q[wr_slot] <= tbl_mask;
				ent_sel_q[wr_slot]  <= tbl_sel;
				ent_act_q[wr_slot]  <= tbl_act;
			end
			tbl_add_done <= add_ok & ~tbl_wr;
			tbl_add_rej  <= tbl_add & (~free_any | tbl_wr);
			if (add_ok & ~tbl_wr) begin
				tbl_add_idx <= free_idx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame queue; frm_ready back-pressures the source

	wire        q_in_ready;
	wire        q_valid;
	wire        q_ready;
	wire [96:0] q_data;
	reg         dec_valid_q;

	assign frm_ready = q_in_ready & ce;
	assign q_ready   = ce & (~dec_valid_q | dec_ready);
	assign dec_valid = dec_valid_q;

	mfs_fifo #(
		.W     (`MFS_FIFO_W),
		.DEPTH (`MFS_FIFO_DEPTH),
		.AW    (`MFS_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.ce        (ce),
		.in_valid  (frm_valid),
		.in_ready  (q_in_ready),
		.in_data   ({frm_port, frm_src, frm_dst}),
		.out_valid (q_valid),
		.out_ready (q_ready),
		.out_data  (q_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// lookup: lowest-numbered hitting entry of the frame's own port decides

	wire        lk_port;
	wire [47:0] lk_src;
	wire [47:0] lk_dst;
	reg         lk_fwd;
	integer     li;

	assign lk_port = q_data[96];
	assign lk_src  = q_data[95:48];
	assign lk_dst  = q_data[47:0];

	always @* begin
		lk_fwd = 1'b1;
		for (li = `MFS_TBL_DEPTH - 1; li >= 0; li = li - 1) begin
			if (ent_hit(ent_addr_q[{lk_port, li[4:0]}], ent_mask_q[{lk_port, li[4:0]}],
				(ent_sel_q[{lk_port, li[4:0]}] == `MFS_SEL_DST) ? lk_dst : lk_src)) begin
				// reject drops, accept forwards, per selected address
				lk_fwd = (ent_act_q[{lk_port, li[4:0]}] == `MFS_ACT_ACCEPT);
			end
		end
		if (((lk_port == `MFS_PORT_ETH) & ~flt_en_eth) |
			((lk_port == `MFS_PORT_RAD) & ~flt_en_rad)) begin
			lk_fwd = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			dec_valid_q <= 1'b0;
			dec_port    <= `MFS_PORT_ETH;
			dec_fwd     <= 1'b0;
			dec_src     <= `MFS_ENT_RST;
			dec_dst     <= `MFS_ENT_RST;
		end else if (ce) begin
			if (q_ready) begin
				dec_valid_q <= q_valid;
				if (q_valid) begin
					dec_port <= lk_port;
					dec_fwd  <= lk_fwd;
					dec_src  <= lk_src;
					dec_dst  <= lk_dst;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// radio resend: a nack asks the transmitter to send the same frame again

	always @(posedge clk) begin
		if (srst) begin
			rad_resend   <= 1'b0;
			rad_wait_ack <= 1'b0;
		end else if (ce) begin
			rad_resend <= rad_nack & rad_wait_ack;
			if (rad_ack) begin
				rad_wait_ack <= 1'b0;
			end else if (rad_tx_done) begin
				rad_wait_ack <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// statistics events

	wire        rx_over;
	wire        rx_runt;
	wire [9:0]  ev;

	assign rx_over = eth_rx_done & (eth_rx_len > `MFS_ETH_MAX_LEN);
	assign rx_runt = eth_rx_done & (eth_rx_len < `MFS_ETH_MIN_LEN);

	assign ev[`MFS_C_ETH_TX]   = eth_tx_done;
	assign ev[`MFS_C_ETH_RX]   = eth_rx_done;
	// any reason a frame went bad also adds to the total
	assign ev[`MFS_C_ETH_ERR]  = eth_err | eth_crc_err | eth_col_err | rx_over | rx_runt;
	assign ev[`MFS_C_ETH_CRC]  = eth_crc_err;
	assign ev[`MFS_C_ETH_COL]  = eth_col_err;
	assign ev[`MFS_C_ETH_OVER] = rx_over;
	assign ev[`MFS_C_ETH_RUNT] = rx_runt;
	assign ev[`MFS_C_RAD_TX]   = rad_tx_done;
	assign ev[`MFS_C_RAD_RETX] = rad_nack & rad_wait_ack;
	assign ev[`MFS_C_RAD_RX]   = rad_rx_done;

	////////////////////////////////////////////////////////////////////////////
	// refresh timer

	reg  [29:0] tmr_q;
	wire        tick;

	assign tick = (tmr_q == REF_LAST);

	always @(posedge clk) begin
		if (srst) begin
			tmr_q      <= 30'h0000000;
			stats_tick <= 1'b0;
		end else if (ce) begin
			tmr_q      <= tick ? 30'h0000000 : tmr_q + 30'h0000001;
			stats_tick <= tick;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// live counters and readable copies; an event in a clear cycle still counts

	reg  [31:0] cnt_q  [0:`MFS_NUM_CNT-1];
	reg  [31:0] snap_q [0:`MFS_NUM_CNT-1];

	genvar gi;
	generate
		for (gi = 0; gi < `MFS_NUM_CNT; gi = gi + 1) begin : g_cnt
			wire clr_i;
			assign clr_i = (gi < `MFS_NUM_ETH_CNT) ? clr_eth : clr_rad;
			always @(posedge clk) begin
				if (srst) begin
					cnt_q[gi]  <= `MFS_CNT_RST;
					snap_q[gi] <= `MFS_CNT_RST;
				end else if (ce) begin
					if (clr_i) begin
						cnt_q[gi]  <= {31'h0000000, ev[gi]};
						snap_q[gi] <= `MFS_CNT_RST;
					end else begin
						cnt_q[gi] <= cnt_q[gi] + {31'h0000000, ev[gi]};
						if (tick) begin
							snap_q[gi] <= cnt_q[gi];
						end
					end
				end
			end
		end
	endgenerate

	assign eth_tx_cnt   = snap_q[`MFS_C_ETH_TX];
	assign eth_rx_cnt   = snap_q[`MFS_C_ETH_RX];
	assign eth_err_cnt  = snap_q[`MFS_C_ETH_ERR];
	assign eth_crc_cnt  = snap_q[`MFS_C_ETH_CRC];
	assign eth_col_cnt  = snap_q[`MFS_C_ETH_COL];
	assign eth_over_cnt = snap_q[`MFS_C_ETH_OVER];
	assign eth_runt_cnt = snap_q[`MFS_C_ETH_RUNT];
	assign rad_tx_cnt   = snap_q[`MFS_C_RAD_TX];
	assign rad_retx_cnt = snap_q[`MFS_C_RAD_RETX];
	assign rad_rx_cnt   = snap_q[`MFS_C_RAD_RX];

	////////////////////////////////////////////////////////////////////////////
	// per-interval radio counts for the rate figures

	reg  [31:0] iv_tx_q;
	reg  [31:0] iv_rx_q;

	always @(posedge clk) begin
		if (srst) begin
			iv_tx_q     <= `MFS_CNT_RST;
			iv_rx_q     <= `MFS_CNT_RST;
			rad_tx_rate <= `MFS_CNT_RST;
			rad_rx_rate <= `MFS_CNT_RST;
		end else if (ce) begin
			if (clr_rad | tick) begin
				iv_tx_q <= {31'h0000000, ev[`MFS_C_RAD_TX]};
				iv_rx_q <= {31'h0000000, ev[`MFS_C_RAD_RX]};
			end else begin
				iv_tx_q <= iv_tx_q + {31'h0000000, ev[`MFS_C_RAD_TX]};
				iv_rx_q <= iv_rx_q + {31'h0000000, ev[`MFS_C_RAD_RX]};
			end
			if (clr_rad) begin
				rad_tx_rate <= `MFS_CNT_RST;
				rad_rx_rate <= `MFS_CNT_RST;
			end else if (tick) begin
				// the event of the tick cycle falls in the next interval
				rad_tx_rate <= iv_tx_q / `MFS_RATE_DIV;
				rad_rx_rate <= iv_rx_q / `MFS_RATE_DIV;
			end
		end
	end

endmodule

`default_nettype wire

// *** inc/mfs_regs.vh ***
// constants for the per-port frame filter and statistics block
// assumes a single 100 MHz system clock and plain-port control
`ifndef MFS_REGS_VH
`define MFS_REGS_VH

// table geometry
`define MFS_TBL_DEPTH   32
`define MFS_IDX_W       5
`define MFS_ADDR_W      48
`define MFS_ENT_RST     48'h000000000000

// port selectors
`define MFS_PORT_ETH    1'b0
`define MFS_PORT_RAD    1'b1

// entry selector and action encodings
`define MFS_SEL_SRC     1'b0
`define MFS_SEL_DST     1'b1
`define MFS_ACT_ACCEPT  1'b0
`define MFS_ACT_REJECT  1'b1

// frame length limits in bytes, crc included
`define MFS_ETH_MAX_LEN 16'd1518
`define MFS_ETH_MIN_LEN 16'd64

// refresh timing
`define MFS_CLK_HZ      100000000
`define MFS_REFRESH_SEC 10
`define MFS_RATE_DIV    32'd10

// statistics counter slots
`define MFS_NUM_CNT     10
`define MFS_NUM_ETH_CNT 7
`define MFS_C_ETH_TX    0
`define MFS_C_ETH_RX    1
`define MFS_C_ETH_ERR   2
`define MFS_C_ETH_CRC   3
`define MFS_C_ETH_COL   4
`define MFS_C_ETH_OVER  5
`define MFS_C_ETH_RUNT  6
`define MFS_C_RAD_TX    7
`define MFS_C_RAD_RETX  8
`define MFS_C_RAD_RX    9
`define MFS_CNT_RST     32'h00000000

// frame queue
`define MFS_FIFO_DEPTH  32
`define MFS_FIFO_AW     5
`define MFS_FIFO_W      97

`endif

// *** src/mfs_fifo.v ***
// synchronous fifo of flip-flops with valid/ready on both sides
// assumes depth is a power of two and one clock for both sides
`default_nettype none

module mfs_fifo #(
	parameter W     = 97,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire         clk,
	input  wire         srst,
	input  wire         ce,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);

	reg  [W-1:0] mem_q [0:DEPTH-1];
	reg  [AW:0]  wp_q;
	reg  [AW:0]  rp_q;
	wire         empty;
	wire         full;
	wire         push;
	wire         pop;

	assign empty     = (wp_q == rp_q);
	assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem_q[rp_q[AW-1:0]];
	assign push      = ce & in_valid & ~full;
	assign pop       = ce & out_ready & ~empty;

	always @(posedge clk) begin
		if (srst) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end

	// storage needs no reset; reads are gated by empty
	always @(posedge clk) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= in_data;
		end
	end

endmodule

`default_nettype wire

// *** test/mfs_chk_sva.sv ***
// port assertions for the frame filter and statistics block
// assumes one clock domain; checker sees only the block's ports
`default_nettype none
module mfs_chk #(
	parameter REFRESH_CYCLES = 100
) (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        ce,
	input wire logic        tbl_wr,
	input wire logic        tbl_add,
	input wire logic        tbl_full,
	input wire logic        tbl_add_done,
	input wire logic        tbl_add_rej,
	input wire logic        dec_valid,
	input wire logic        dec_ready,
	input wire logic        dec_port,
	input wire logic        dec_fwd,
	input wire logic [47:0] dec_src,
	input wire logic        flt_en_eth,
	input wire logic        flt_en_rad,
	input wire logic        rad_nack,
	input wire logic        rad_wait_ack,
	input wire logic        rad_resend,
	input wire logic        stats_tick,
	input wire logic        clr_eth,
	input wire logic [31:0] eth_tx_cnt,
	input wire logic [31:0] eth_err_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// enabled cycles since the last copy update, to check the refresh period
	logic [31:0] since_q;
	logic        seen_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			since_q <= 32'h0;
			seen_q <= 1'b0;
		end else if (ce) begin
			since_q <= stats_tick ? 32'h1 : since_q + 32'h1;
			seen_q <= seen_q | stats_tick;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	////////////////////////////////////////
	AST_ADD_REFUSED: assert property (ce && tbl_add && (tbl_full || tbl_wr) |=> tbl_add_rej)
		else $error("add not refused");
	AST_ADD_TAKEN: assert property (ce && tbl_add && !tbl_wr && !tbl_full |=> tbl_add_done)
		else $error("add not accepted");
	AST_DEC_HOLD: assert property (dec_valid && !dec_ready |=> dec_valid && $stable({dec_fwd, dec_src}))
		else $error("verdict changed while stalled");
	AST_DROP_NEEDS_EN: assert property (dec_valid && !dec_fwd |-> (dec_port ? flt_en_rad : flt_en_eth))
		else $error("drop with filter off");
	AST_RESEND: assert property (ce && rad_nack && rad_wait_ack |=> rad_resend)
		else $error("no resend after nack");
	AST_RESEND_CAUSE: assert property (rad_resend |-> $past(rad_nack))
		else $error("resend without nack");
	AST_COPY_HOLD: assert property (!clr_eth ##1 !stats_tick |-> $stable(eth_tx_cnt))
		else $error("copy moved between ticks");
	AST_CLEAR: assert property (ce && clr_eth |=> eth_tx_cnt == 32'h0 && eth_err_cnt == 32'h0)
		else $error("clear left counts");
	AST_TICK_SPACED: assert property (stats_tick |=> !stats_tick [*8])
		else $error("ticks too close");
	AST_TICK_PERIOD: assert property (ce && stats_tick && seen_q |-> since_q == REFRESH_CYCLES)
		else $error("refresh period wrong");
	cover property (tbl_add_rej);
	cover property (dec_valid && dec_ready && !dec_fwd);
	cover property (rad_resend);
	cover property (stats_tick);
endmodule
bind mfs_filter_stats mfs_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (.clk(clk), .srst(srst),
	.ce(ce), .tbl_wr(tbl_wr), .tbl_add(tbl_add), .tbl_full(tbl_full), .tbl_add_done(tbl_add_done),
	.tbl_add_rej(tbl_add_rej), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_port(dec_port),
	.dec_fwd(dec_fwd), .dec_src(dec_src), .flt_en_eth(flt_en_eth), .flt_en_rad(flt_en_rad),
	.rad_nack(rad_nack), .rad_wait_ack(rad_wait_ack), .rad_resend(rad_resend),
	.stats_tick(stats_tick), .clr_eth(clr_eth), .eth_tx_cnt(eth_tx_cnt), .eth_err_cnt(eth_err_cnt));
`default_nettype wire

// *** test/mfs_far_model.sv ***
// far side: takes verdicts and answers radio frames with ack or nack
// assumes one clock; stall holds verdicts back, load sets the nack budget
`default_nettype none
module mfs_far_model (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       stall,
	input  wire logic       load,
	input  wire logic [3:0] nack_budget,
	input  wire logic       rad_wait_ack,
	output logic            dec_ready,
	output logic            rad_ack,
	output logic            rad_nack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left_q;
	logic [1:0] gap_q;
	assign dec_ready = !stall;
	// slow answer on purpose: every fourth waiting cycle, nacks first
	always_ff @(posedge clk) begin
		rad_ack <= 1'b0;
		rad_nack <= 1'b0;
		if (srst) begin
			left_q <= 4'h0;
			gap_q <= 2'h0;
		end else if (load) begin
			left_q <= nack_budget;
		end else if (rad_wait_ack && !rad_ack && !rad_nack) begin
			gap_q <= gap_q + 2'h1;
			if (gap_q == 2'h3 && left_q != 4'h0) begin
				rad_nack <= 1'b1;
				left_q <= left_q - 4'h1;
			end else if (gap_q == 2'h3) begin
				rad_ack <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the frame filter and statistics block
// assumes the far-side model takes verdicts and answers radio frames
`default_nettype none
`include "mfs_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [47:0] ALL = 48'hffffffffffff;
	localparam logic [47:0] A = 48'h0200000000a1, B = 48'h0200000000b2, C = 48'h0200000000c3;
	localparam logic [47:0] D = 48'h020000001000, F = 48'h0a0000000005;
	logic        clk = 0, srst = 1, ce = 1, flt_en_eth = 1, flt_en_rad = 1;
	logic        tbl_wr = 0, tbl_add = 0, tbl_port = 0, tbl_sel = 0, tbl_act = 0;
	logic [4:0]  tbl_idx = 0;
	logic [47:0] tbl_addr = 0, tbl_mask = 0, frm_src = 0, frm_dst = 0;
	logic        frm_valid = 0, frm_port = 0, stall = 0, load = 0;
	logic        eth_tx_done = 0, eth_rx_done = 0, eth_err = 0, eth_crc_err = 0, eth_col_err = 0;
	logic        rad_tx_done = 0, rad_rx_done = 0, clr_eth = 0, clr_rad = 0;
	logic [15:0] eth_rx_len = 0;
	logic [3:0]  nack_budget = 0;
	wire         tbl_full, tbl_add_done, tbl_add_rej, frm_ready, dec_valid, dec_ready, dec_port;
	wire         dec_fwd, rad_ack, rad_nack, rad_resend, rad_wait_ack, stats_tick;
	wire [4:0]   tbl_add_idx;
	wire [47:0]  dec_src, dec_dst;
	wire [31:0]  eth_tx_cnt, eth_rx_cnt, eth_err_cnt, eth_crc_cnt, eth_col_cnt, eth_over_cnt;
	wire [31:0]  eth_runt_cnt, rad_tx_cnt, rad_retx_cnt, rad_rx_cnt, rad_tx_rate, rad_rx_rate;
	wire [383:0] cnt_all = {eth_tx_cnt, eth_rx_cnt, eth_err_cnt, eth_crc_cnt, eth_col_cnt,
		eth_over_cnt, eth_runt_cnt, rad_tx_cnt, rad_retx_cnt, rad_rx_cnt, rad_tx_rate, rad_rx_rate};
	logic [97:0] exp_q[$];
	int          n_errors = 0, tests_run = 0, i;
	mfs_filter_stats #(.REFRESH_CYCLES(100)) dut (.clk(clk), .srst(srst), .ce(ce),
		.flt_en_eth(flt_en_eth), .flt_en_rad(flt_en_rad), .tbl_wr(tbl_wr),
		.tbl_add(tbl_add), .tbl_port(tbl_port), .tbl_idx(tbl_idx), .tbl_addr(tbl_addr),
		.tbl_mask(tbl_mask), .tbl_sel(tbl_sel), .tbl_act(tbl_act), .tbl_full(tbl_full),
		.tbl_add_done(tbl_add_done), .tbl_add_rej(tbl_add_rej), .tbl_add_idx(tbl_add_idx),
		.frm_valid(frm_valid), .frm_ready(frm_ready), .frm_port(frm_port),
		.frm_src(frm_src), .frm_dst(frm_dst), .dec_valid(dec_valid), .dec_ready(dec_ready),
		.dec_port(dec_port), .dec_fwd(dec_fwd), .dec_src(dec_src), .dec_dst(dec_dst),
		.eth_tx_done(eth_tx_done), .eth_rx_done(eth_rx_done), .eth_rx_len(eth_rx_len),
		.eth_err(eth_err), .eth_crc_err(eth_crc_err), .eth_col_err(eth_col_err),
		.clr_eth(clr_eth), .rad_tx_done(rad_tx_done), .rad_ack(rad_ack),
		.rad_nack(rad_nack), .rad_rx_done(rad_rx_done), .clr_rad(clr_rad),
		.rad_resend(rad_resend), .rad_wait_ack(rad_wait_ack), .eth_tx_cnt(eth_tx_cnt),
		.eth_rx_cnt(eth_rx_cnt), .eth_err_cnt(eth_err_cnt), .eth_crc_cnt(eth_crc_cnt),
		.eth_col_cnt(eth_col_cnt), .eth_over_cnt(eth_over_cnt),
		.eth_runt_cnt(eth_runt_cnt), .rad_tx_cnt(rad_tx_cnt), .rad_retx_cnt(rad_retx_cnt),
		.rad_rx_cnt(rad_rx_cnt), .rad_tx_rate(rad_tx_rate), .rad_rx_rate(rad_rx_rate),
		.stats_tick(stats_tick));
	mfs_far_model far (.clk(clk), .srst(srst), .stall(stall), .load(load), .nack_budget(nack_budget),
		.rad_wait_ack(rad_wait_ack), .dec_ready(dec_ready), .rad_ack(rad_ack), .rad_nack(rad_nack));
	always #5 clk = ~clk;
	////////////////////////////////////////
	task automatic report(input logic bad, input string m);
		tests_run++;
		if (bad) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_b(input logic [7:0] g, e); report(g !== e, "table or ready"); endtask
	task automatic chk_f(input logic [97:0] g, e); report(g !== e, "verdict"); endtask
	task automatic chk_c(input logic [383:0] g, e); report(g !== e, "counters"); endtask
	task automatic close_out;
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// op is {add, write}; both at once checks that the write wins
	task automatic tbl_op(input logic [1:0] op, input logic p, input logic [4:0] x,
		input logic [47:0] a, m, input logic s, act);
		@(negedge clk);
		{tbl_add, tbl_wr, tbl_port, tbl_idx, tbl_addr, tbl_mask, tbl_sel, tbl_act} =
			{op, p, x, a, m, s, act};
		@(negedge clk);
		{tbl_add, tbl_wr} = 2'b00;
	endtask
	task automatic add_chk(input logic p, input logic [47:0] a, m, input logic s, act,
		input logic [7:0] e);
		tbl_op(2'b10, p, 5'h0, a, m, s, act);
		chk_b({tbl_full, tbl_add_rej, tbl_add_done, tbl_add_idx}, e);
	endtask
	task automatic send(input logic p, input logic [47:0] s, d, input logic f);
		@(negedge clk);
		{frm_valid, frm_port, frm_src, frm_dst} = {1'b1, p, s, d};
		while (frm_ready !== 1'b1) @(negedge clk);
		exp_q.push_back({p, f, s, d});
		@(negedge clk);
		frm_valid = 1'b0;
	endtask
	task automatic drain; while (exp_q.size() != 0) @(negedge clk); endtask
	task automatic wait_tick; do @(negedge clk); while (stats_tick !== 1'b1); endtask
	always @(posedge clk) begin
		if (!srst && dec_valid === 1'b1 && dec_ready === 1'b1)
			chk_f({dec_port, dec_fwd, dec_src, dec_dst}, exp_q.size() ? exp_q.pop_front() : 98'h0);
	end
	////////////////////////////////////////
	initial begin
		repeat (5) @(negedge clk);
		srst = 1'b0;
		add_chk(0, A, ALL, 0, 1, 8'h20);
		add_chk(0, B, ALL, 1, 0, 8'h21);
		add_chk(1, D, 48'hffffffffff00, 0, 0, 8'h20);
		add_chk(1, D + 1, ALL, 0, 1, 8'h21);
		add_chk(1, C, ALL, 1, 1, 8'h22);
		send(0, A, F, 0);
		send(0, F, B, 1);
		send(1, D + 1, F, 1);
		send(1, F, C, 0);
		send(0, F, C, 1);
		send(1, C, F, 1);
		tbl_op(2'b01, 0, 5'h0, 48'h0, 48'h0, 0, 1);
		send(0, A, F, 1);
		add_chk(0, A, ALL, 0, 1, 8'h20);
		drain;
		flt_en_eth = 1'b0;
		send(0, A, F, 1);
		drain;
		for (i = 3; i < 32; i++) add_chk(1, 48'h030000000000 + 48'(i), ALL, 1, 0, {i == 31, 2'b01, 5'(i)});
		add_chk(1, F, ALL, 0, 0, 8'hdf);
		// verdict side stalls so the queue fills until it refuses
		stall = 1'b1;
		for (i = 0; i < 33; i++) send(1, 48'h0b0000000000 + 48'(i), F, 1);
		repeat (2) @(negedge clk);
		chk_b({7'h0, frm_ready}, 8'h00);
		stall = 1'b0;
		drain;
		{load, nack_budget} = 5'h12;
		@(negedge clk);
		load = 1'b0;
		wait_tick;
		for (i = 0; i < 30; i++) begin
			{eth_tx_done, eth_rx_done, eth_err, eth_crc_err, eth_col_err, rad_tx_done, rad_rx_done} =
				{i < 3, i < 3, i == 3, i == 4, i == 5, i < 20, 1'b1};
			eth_rx_len = i == 0 ? `MFS_ETH_MAX_LEN + 16'd1 : i == 1 ? `MFS_ETH_MIN_LEN - 16'd1 : 16'd100;
			@(negedge clk);
		end
		{eth_tx_done, eth_rx_done, eth_err, eth_crc_err, eth_col_err, rad_tx_done, rad_rx_done} = 7'h0;
		wait_tick;
		chk_c(cnt_all, {32'd3, 32'd3, 32'd5, 32'd1, 32'd1, 32'd1, 32'd1, 32'd20, 32'd2, 32'd30, 32'd20 / `MFS_RATE_DIV, 32'd30 / `MFS_RATE_DIV});
		{clr_eth, clr_rad} = 2'b11;
		@(negedge clk);
		{clr_eth, clr_rad} = 2'b00;
		chk_c(cnt_all, 384'h0);
		// enable low: the add is ignored and the flags hold
		ce = 1'b0;
		tbl_op(2'b10, 0, 5'h0, C, ALL, 1, 0);
		chk_b({tbl_full, tbl_add_rej, tbl_add_done, tbl_add_idx}, 8'h1f);
		chk_b({7'h0, frm_ready}, 8'h00);
		ce = 1'b1;
		tbl_op(2'b11, 0, 5'h4, D, ALL, 0, 0);
		chk_b({tbl_full, tbl_add_rej, tbl_add_done, tbl_add_idx}, 8'h5f);
		add_chk(0, C, ALL, 1, 0, 8'h22);
		add_chk(0, F, ALL, 0, 0, 8'h23);
		close_out;
	end
	// run needs about 310 cycles; the 15000-cycle limit, near fifty times that, cuts a hang short
	initial begin
		#150us;
		n_errors++;
		close_out;
	end
endmodule
`default_nettype wire
